// ==== rtl/bti_pkg.sv ====
// Behaviour
// - io bit set/clear forces one addressed I/O bit, two cycles, no flags.
// - left shift inserts zero at bit 0; Z, C, N, V updated; one cycle.
// - right shift inserts zero at bit 7; Z, C, N, V updated; one cycle.
// - left rotate takes old carry into bit 0, bit 7 into carry; one cycle.
// - right rotate takes old carry into bit 7, bit 0 into carry; one cycle.
// - signed right shift keeps the sign bit; Z, C, N, V updated; one cycle.
// - copy selected register bit into T flag in one cycle, others untouched.
// - copy T flag into selected register bit in one cycle, flags untouched.
// - single-cycle set or clear of any one status flag, irq enable included.
// - pre-decrement load lowers the pointer first, then reads; two cycles.
// - post-increment load reads first, then raises the pointer; two cycles.
// - displacement load reads Y or Z plus q, pointer kept; two cycles.
// - post-increment write stores, then raises the pointer; two cycles.
// - pre-decrement write lowers the pointer, then stores there; two cycles.
// - displacement write stores at Y or Z plus q, pointer kept; two cycles.
// - direct fetch and write move one byte at a given address; two cycles.
// - code fetch reads program byte at Z into Rd or r0; three cycles.
// - push writes the source register onto the stack in two cycles.
// - pop loads the destination register from the stack in two cycles.
// - watchdog restart takes one cycle and signals the watchdog timer.
// - break is only a request to the debug system.
`default_nettype none
package bti_pkg;
  localparam int WB_AW = 8;
  localparam int IO_AW = 6;
  localparam int NUM_GPR = 32;
  localparam int BYTE_MSB = 7;
  localparam int GPR_SEL_BIT = 7;
  localparam int GPR_IDX_MSB = 6;
  localparam int GPR_IDX_LSB = 2;
  // register map, byte addresses
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_SP = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // status flag positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  localparam logic [7:0] FLAG_T_MASK = 8'h40;
  // pointer pairs live in the top six working registers
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [4:0] PTR_HI_SEL = 5'h01;
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_PREDEC = 2'h2;
  localparam logic [1:0] MODE_R0 = 2'h3;
  // execution lengths in clock cycles and step codes
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] STEP_FIRST = 2'h0;
  localparam logic [1:0] STEP_SECOND = 2'h1;
  localparam logic [1:0] STEP_INC = 2'h1;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_IO_SET = 5'h01, OP_IO_CLR = 5'h02,
    OP_SHL = 5'h03, OP_SHR = 5'h04, OP_ROTL = 5'h05, OP_ROTR = 5'h06,
    OP_SAR = 5'h07, OP_BIT_TO_T = 5'h08, OP_T_TO_BIT = 5'h09,
    OP_FLAG_SET = 5'h0a, OP_FLAG_CLR = 5'h0b, OP_IRQ_ON = 5'h0c,
    OP_IRQ_OFF = 5'h0d, OP_IND_LOAD = 5'h0e, OP_OFS_LOAD = 5'h0f,
    OP_DIR_FETCH = 5'h10, OP_IND_WRITE = 5'h11, OP_OFS_WRITE = 5'h12,
    OP_DIR_WRITE = 5'h13, OP_CODE_FETCH = 5'h14, OP_PUSH = 5'h15,
    OP_POP = 5'h16, OP_WDOG = 5'h17, OP_BREAK = 5'h18
  } bti_op_type;

  typedef struct packed {
    logic [5:0] disp;
    logic [1:0] mode;
    logic [1:0] ptr;
    logic [2:0] bsel;
    logic [4:0] reg_idx;
    bti_op_type op;
  } bti_cmd_type;
  localparam int CMD_W = $bits(bti_cmd_type);

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic re;
    logic we;
  } bti_dm_req_type;

  typedef struct packed {
    logic [IO_AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic we;
  } bti_io_req_type;

  typedef struct packed {
    logic [15:0] addr;
    logic re;
  } bti_pm_req_type;

  function automatic logic [1:0] bti_op_len(bti_op_type op);
    case (op)
      OP_IO_SET, OP_IO_CLR, OP_IND_LOAD, OP_OFS_LOAD, OP_DIR_FETCH,
      OP_IND_WRITE, OP_OFS_WRITE, OP_DIR_WRITE, OP_PUSH, OP_POP:
        return LEN_TWO;
      OP_CODE_FETCH: return LEN_THREE;
      default: return LEN_ONE;
    endcase
  endfunction

  function automatic logic [4:0] bti_ptr_lo(logic [1:0] ptr);
    case (ptr)
      PTR_X: return PTR_X_LO;
      PTR_Y: return PTR_Y_LO;
      default: return PTR_Z_LO;
    endcase
  endfunction

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] bti_merge(logic [31:0] old_w,
                                            logic [31:0] new_w,
                                            logic [3:0] sel);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// ==== rtl/bti_shift_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
module bti_shift_unit (
  // operation and operands
  input wire bti_pkg::bti_op_type op,
  input wire logic [7:0] value,
  input wire logic [7:0] flags_in,
  // result
  output logic [7:0] result,
  output logic [7:0] flags_out
);
  logic carry;

  // one-place shifts and rotates; S and H are left alone
  always_comb begin
    result = value;
    carry = flags_in[bti_pkg::FLAG_C];
    flags_out = flags_in;
    case (op)
      bti_pkg::OP_SHL: begin
        result = {value[bti_pkg::BYTE_MSB-1:0], 1'b0};
        carry = value[bti_pkg::BYTE_MSB];
      end
      bti_pkg::OP_SHR: begin
        result = {1'b0, value[bti_pkg::BYTE_MSB:1]};
        carry = value[0];
      end
      bti_pkg::OP_ROTL: begin
        result = {value[bti_pkg::BYTE_MSB-1:0], carry};
        carry = value[bti_pkg::BYTE_MSB];
      end
      bti_pkg::OP_ROTR: begin
        result = {carry, value[bti_pkg::BYTE_MSB:1]};
        carry = value[0];
      end
      bti_pkg::OP_SAR: begin
        result = {value[bti_pkg::BYTE_MSB], value[bti_pkg::BYTE_MSB:1]};
        carry = value[0];
      end
      default: begin
        result = value;
      end
    endcase
    if (op inside {bti_pkg::OP_SHL, bti_pkg::OP_SHR, bti_pkg::OP_ROTL,
                   bti_pkg::OP_ROTR, bti_pkg::OP_SAR}) begin
      flags_out[bti_pkg::FLAG_C] = carry;
      flags_out[bti_pkg::FLAG_Z] = (result == 8'h00);
      flags_out[bti_pkg::FLAG_N] = result[bti_pkg::BYTE_MSB];
      // overflow is N xor C after the move
      flags_out[bti_pkg::FLAG_V] = result[bti_pkg::BYTE_MSB] ^ carry;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/bti_exec_unit.sv ====
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module bti_exec_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [bti_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // data memory and stack
  output bti_pkg::bti_dm_req_type dm_req,
  input wire logic [7:0] dm_rdata,
  // i/o register space
  output bti_pkg::bti_io_req_type io_req,
  // program memory
  output bti_pkg::bti_pm_req_type pm_req,
  input wire logic [7:0] pm_rdata,
  // core side events
  output logic wdt_restart,
  output logic dbg_break_req,
  output logic busy
);
  typedef logic [bti_pkg::NUM_GPR-1:0][7:0] bti_gpr_type;

  typedef struct packed {
    bti_gpr_type gpr;
    logic [7:0] flags;
    logic [15:0] sp;
    logic [15:0] addr;
    bti_pkg::bti_cmd_type cmd;
    logic busy;
    logic [1:0] step;
    logic ack;
    logic [31:0] dat;
    bti_pkg::bti_dm_req_type dm;
    bti_pkg::bti_io_req_type io;
    bti_pkg::bti_pm_req_type pm;
    logic wdt;
    logic brk;
  } bti_state_type;

  bti_state_type st;
  bti_state_type next_st;
  bti_pkg::bti_op_type op;
  logic [1:0] psel;
  logic [4:0] plo;
  logic [15:0] ptr_val;
  logic [15:0] ea;
  logic [4:0] rd_idx;
  logic [7:0] op_val;
  logic [7:0] sh_res;
  logic [7:0] sh_flags;
  logic [4:0] gidx;

  // write a 16-bit pointer back into its register pair
  function automatic bti_gpr_type put_ptr(bti_gpr_type g, logic [4:0] lo,
                                          logic [15:0] v);
    bti_gpr_type r;
    r = g;
    r[lo] = v[7:0];
    r[lo | bti_pkg::PTR_HI_SEL] = v[15:8];
    return r;
  endfunction

  assign op = st.cmd.op;
  assign rd_idx = st.cmd.reg_idx;
  assign op_val = st.gpr[rd_idx];
  assign gidx = wb_adr_i[bti_pkg::GPR_IDX_MSB:bti_pkg::GPR_IDX_LSB];

  // pointer choice: code fetch is tied to Z, displacement to Y or Z
  always_comb begin
    psel = st.cmd.ptr;
    if (op == bti_pkg::OP_CODE_FETCH) begin
      psel = bti_pkg::PTR_Z;
    end else if ((op inside {bti_pkg::OP_OFS_LOAD, bti_pkg::OP_OFS_WRITE})
                 && (psel != bti_pkg::PTR_Z)) begin
      psel = bti_pkg::PTR_Y;
    end
  end
  assign plo = bti_pkg::bti_ptr_lo(psel);
  assign ptr_val = {st.gpr[plo | bti_pkg::PTR_HI_SEL], st.gpr[plo]};

  // effective data address for the first step of a memory op
  always_comb begin
    ea = ptr_val;
    if (op inside {bti_pkg::OP_DIR_FETCH, bti_pkg::OP_DIR_WRITE}) begin
      ea = st.addr;
    end else if (op inside {bti_pkg::OP_OFS_LOAD, bti_pkg::OP_OFS_WRITE}) begin
      ea = ptr_val + 16'(st.cmd.disp);
    end else if (st.cmd.mode == bti_pkg::MODE_PREDEC) begin
      ea = ptr_val - bti_pkg::PTR_STEP;
    end
  end

  bti_shift_unit u_shift (
    .op(op),
    .value(op_val),
    .flags_in(st.flags),
    .result(sh_res),
    .flags_out(sh_flags)
  );

  // next state: bus slave, then the execution sequencer
  always_comb begin
    logic [31:0] wr;
    wr = '0;
    next_st = st;
    next_st.ack = 1'b0;
    next_st.dm.re = 1'b0;
    next_st.dm.we = 1'b0;
    next_st.io.we = 1'b0;
    next_st.pm.re = 1'b0;
    next_st.wdt = 1'b0;
    next_st.brk = 1'b0;
    if (wb_cyc_i && wb_stb_i && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.dat = '0;
      if (wb_adr_i[bti_pkg::GPR_SEL_BIT]) begin
        next_st.dat = 32'(st.gpr[gidx]);
      end else begin
        case (wb_adr_i)
          bti_pkg::OFS_CMD: next_st.dat = 32'(st.cmd);
          bti_pkg::OFS_ADDR: next_st.dat = 32'(st.addr);
          bti_pkg::OFS_FLAGS: next_st.dat = 32'(st.flags);
          bti_pkg::OFS_SP: next_st.dat = 32'(st.sp);
          bti_pkg::OFS_STATUS: next_st.dat = 32'(st.busy);
          default: next_st.dat = '0;
        endcase
      end
      wr = bti_pkg::bti_merge(next_st.dat, wb_dat_i, wb_sel_i);
      // software writes are dropped while an operation runs
      if (wb_we_i && !st.busy) begin
        if (wb_adr_i[bti_pkg::GPR_SEL_BIT]) begin
          next_st.gpr[gidx] = wr[7:0];
        end else begin
          case (wb_adr_i)
            bti_pkg::OFS_CMD: begin
              next_st.cmd = bti_pkg::bti_cmd_type'(wr[bti_pkg::CMD_W-1:0]);
              next_st.busy = 1'b1;
              next_st.step = bti_pkg::STEP_FIRST;
            end
            bti_pkg::OFS_ADDR: next_st.addr = wr[15:0];
            bti_pkg::OFS_FLAGS: next_st.flags = wr[7:0];
            bti_pkg::OFS_SP: next_st.sp = wr[15:0];
            default: next_st.addr = st.addr;
          endcase
        end
      end
    end
    if (st.busy) begin
      if (st.step == bti_pkg::bti_op_len(op) - bti_pkg::STEP_INC) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.step = st.step + bti_pkg::STEP_INC;
      end
      if (st.step == bti_pkg::STEP_FIRST) begin
        case (op)
          bti_pkg::OP_IO_SET, bti_pkg::OP_IO_CLR: begin
            // masked write touches only the addressed bit
            next_st.io.we = 1'b1;
            next_st.io.addr = st.addr[bti_pkg::IO_AW-1:0];
            next_st.io.wmask = 8'h01 << st.cmd.bsel;
            next_st.io.wdata = (op == bti_pkg::OP_IO_SET) ?
                               (8'h01 << st.cmd.bsel) : 8'h00;
          end
          bti_pkg::OP_SHL, bti_pkg::OP_SHR, bti_pkg::OP_ROTL,
          bti_pkg::OP_ROTR, bti_pkg::OP_SAR: begin
            next_st.gpr[rd_idx] = sh_res;
            next_st.flags = sh_flags;
          end
          bti_pkg::OP_BIT_TO_T: begin
            next_st.flags[bti_pkg::FLAG_T] = op_val[st.cmd.bsel];
          end
          bti_pkg::OP_T_TO_BIT: begin
            next_st.gpr[rd_idx][st.cmd.bsel] = st.flags[bti_pkg::FLAG_T];
          end
          bti_pkg::OP_FLAG_SET: next_st.flags[st.cmd.bsel] = 1'b1;
          bti_pkg::OP_FLAG_CLR: next_st.flags[st.cmd.bsel] = 1'b0;
          bti_pkg::OP_IRQ_ON: next_st.flags[bti_pkg::FLAG_I] = 1'b1;
          bti_pkg::OP_IRQ_OFF: next_st.flags[bti_pkg::FLAG_I] = 1'b0;
          bti_pkg::OP_IND_LOAD, bti_pkg::OP_OFS_LOAD, bti_pkg::OP_DIR_FETCH,
          bti_pkg::OP_IND_WRITE, bti_pkg::OP_OFS_WRITE,
          bti_pkg::OP_DIR_WRITE: begin
            next_st.dm.addr = ea;
            next_st.dm.wdata = op_val;
            next_st.dm.re = op inside {bti_pkg::OP_IND_LOAD,
                                       bti_pkg::OP_OFS_LOAD,
                                       bti_pkg::OP_DIR_FETCH};
            next_st.dm.we = !next_st.dm.re;
            if ((op inside {bti_pkg::OP_IND_LOAD, bti_pkg::OP_IND_WRITE}) &&
                (st.cmd.mode == bti_pkg::MODE_PREDEC)) begin
              next_st.gpr = put_ptr(st.gpr, plo, ea);
            end
          end
          bti_pkg::OP_PUSH: begin
            next_st.dm.addr = st.sp;
            next_st.dm.wdata = op_val;
            next_st.dm.we = 1'b1;
          end
          bti_pkg::OP_POP: begin
            // pointer rises before the read
            next_st.sp = st.sp + bti_pkg::PTR_STEP;
            next_st.dm.addr = st.sp + bti_pkg::PTR_STEP;
            next_st.dm.re = 1'b1;
          end
          bti_pkg::OP_CODE_FETCH: begin
            next_st.pm.addr = ptr_val;
            next_st.pm.re = 1'b1;
          end
          bti_pkg::OP_WDOG: next_st.wdt = 1'b1;
          bti_pkg::OP_BREAK: next_st.brk = 1'b1;
          default: next_st.busy = 1'b0;
        endcase
      end else if (st.step == bti_pkg::STEP_SECOND) begin
        // data memory answers in the cycle its strobe is high
        if (op inside {bti_pkg::OP_IND_LOAD, bti_pkg::OP_OFS_LOAD,
                       bti_pkg::OP_DIR_FETCH, bti_pkg::OP_POP}) begin
          next_st.gpr[rd_idx] = dm_rdata;
        end
        if ((op inside {bti_pkg::OP_IND_LOAD, bti_pkg::OP_IND_WRITE}) &&
            (st.cmd.mode == bti_pkg::MODE_POSTINC)) begin
          next_st.gpr = put_ptr(next_st.gpr, plo,
                                ptr_val + bti_pkg::PTR_STEP);
        end
        if (op == bti_pkg::OP_PUSH) begin
          next_st.sp = st.sp - bti_pkg::PTR_STEP;
        end
      end else begin
        // program memory has one cycle of latency
        if (st.cmd.mode == bti_pkg::MODE_R0) begin
          next_st.gpr[bti_pkg::REG_ZERO] = pm_rdata;
        end else begin
          next_st.gpr[rd_idx] = pm_rdata;
        end
        if (st.cmd.mode == bti_pkg::MODE_POSTINC) begin
          next_st.gpr = put_ptr(next_st.gpr, plo,
                                ptr_val + bti_pkg::PTR_STEP);
        end
      end
    end
  end

  // single state register; reset takes constants only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.sp <= bti_pkg::SP_RESET;
      st.flags <= bti_pkg::FLAGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign dm_req = st.dm;
  assign io_req = st.io;
  assign pm_req = st.pm;
  assign wdt_restart = st.wdt;
  assign dbg_break_req = st.brk;
  assign busy = st.busy;

  // helpers read only by the checks below
  logic exec0;
  logic [7:0] flags_w;
  logic [15:0] sp_w;
  logic [2:0] bsel_w;
  logic op_msb;
  logic sel_bit;
  logic t_flag;
  logic [7:0] rotl_exp;
  logic [7:0] rotr_exp;
  logic [7:0] sar_exp;
  assign exec0 = st.busy && (st.step == bti_pkg::STEP_FIRST);
  assign flags_w = st.flags;
  assign sp_w = st.sp;
  assign bsel_w = st.cmd.bsel;
  assign op_msb = op_val[bti_pkg::BYTE_MSB];
  assign sel_bit = op_val[bsel_w];
  assign t_flag = flags_w[bti_pkg::FLAG_T];
  assign rotl_exp = {op_val[6:0], flags_w[bti_pkg::FLAG_C]};
  assign rotr_exp = {flags_w[bti_pkg::FLAG_C], op_val[7:1]};
  assign sar_exp = {op_val[7], op_val[7:1]};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_io_bit_req: assert property (
    exec0 && (op inside {bti_pkg::OP_IO_SET, bti_pkg::OP_IO_CLR}) |=>
    io_req.we && $onehot(io_req.wmask) && st.busy &&
    (io_req.wdata == ((op == bti_pkg::OP_IO_SET) ? io_req.wmask : 8'h00))
    ##1 !st.busy && (flags_w == $past(flags_w, 2)))
    else $error("io bit op wrong strobe, mask or length");
  a_shl_value: assert property (
    exec0 && op == bti_pkg::OP_SHL |=> (op_val == ($past(op_val) << 1)) &&
    (flags_w[bti_pkg::FLAG_C] == $past(op_msb)) && !st.busy)
    else $error("left shift result or carry wrong");
  a_shr_value: assert property (
    exec0 && op == bti_pkg::OP_SHR |=> (op_val == ($past(op_val) >> 1)) &&
    !flags_w[bti_pkg::FLAG_N] && (flags_w[bti_pkg::FLAG_Z] == (op_val == 8'h00)))
    else $error("right shift result or flags wrong");
  a_rotl_value: assert property (
    exec0 && op == bti_pkg::OP_ROTL |=> (op_val == $past(rotl_exp)) &&
    (flags_w[bti_pkg::FLAG_C] == $past(op_msb)))
    else $error("left rotate through carry wrong");
  a_rotr_value: assert property (
    exec0 && op == bti_pkg::OP_ROTR |=> op_val == $past(rotr_exp))
    else $error("right rotate through carry wrong");
  a_sar_sign: assert property (
    exec0 && op == bti_pkg::OP_SAR |=> op_val == $past(sar_exp))
    else $error("signed shift lost the sign");
  a_bit_to_flag: assert property (
    exec0 && op == bti_pkg::OP_BIT_TO_T |=> (t_flag == $past(sel_bit)) &&
    ((flags_w | bti_pkg::FLAG_T_MASK) ==
     ($past(flags_w) | bti_pkg::FLAG_T_MASK)))
    else $error("bit to flag copy wrong");
  a_flag_to_bit: assert property (
    exec0 && op == bti_pkg::OP_T_TO_BIT |=>
    (op_val[bsel_w] == $past(t_flag)) && $stable(flags_w))
    else $error("flag to bit copy wrong");
  a_flag_single: assert property (
    exec0 && op == bti_pkg::OP_FLAG_SET |=> flags_w[bsel_w] && !st.busy)
    else $error("flag set op failed");
  a_predec_addr: assert property (
    exec0 && (op inside {bti_pkg::OP_IND_LOAD, bti_pkg::OP_IND_WRITE}) &&
    st.cmd.mode == bti_pkg::MODE_PREDEC |=>
    (dm_req.addr == $past(ptr_val) - bti_pkg::PTR_STEP) &&
    (ptr_val == dm_req.addr) && (dm_req.re || dm_req.we) ##1 !st.busy)
    else $error("pre-decrement access wrong");
  a_postinc_ptr: assert property (
    exec0 && (op inside {bti_pkg::OP_IND_LOAD, bti_pkg::OP_IND_WRITE}) &&
    st.cmd.mode == bti_pkg::MODE_POSTINC |=>
    dm_req.addr == $past(ptr_val)
    ##1 ptr_val == $past(ptr_val, 2) + bti_pkg::PTR_STEP)
    else $error("post-increment access wrong");
  a_ofs_keep: assert property (
    exec0 && (op inside {bti_pkg::OP_OFS_LOAD, bti_pkg::OP_OFS_WRITE}) |=>
    $stable(ptr_val) ##1 $stable(ptr_val) && !st.busy)
    else $error("displacement op moved the pointer");
  a_push_sp: assert property (
    exec0 && op == bti_pkg::OP_PUSH |=>
    dm_req.we && dm_req.addr == $past(sp_w)
    ##1 sp_w == $past(sp_w, 2) - bti_pkg::PTR_STEP)
    else $error("push address or stack pointer wrong");
  a_code_len: assert property (
    exec0 && op == bti_pkg::OP_CODE_FETCH |-> st.busy[*3] ##1 !st.busy)
    else $error("code fetch not three cycles");
  a_wdog_pulse: assert property (
    exec0 && op == bti_pkg::OP_WDOG |=> wdt_restart && !st.busy)
    else $error("watchdog restart missing");
  a_break_req: assert property (
    exec0 && op == bti_pkg::OP_BREAK |=> dbg_break_req && $stable(flags_w))
    else $error("break request missing");

  c_load: cover property (exec0 && op == bti_pkg::OP_IND_LOAD);
  c_push_pop: cover property (exec0 && op == bti_pkg::OP_PUSH ##[2:40]
                              exec0 && op == bti_pkg::OP_POP);
  c_code: cover property (exec0 && op == bti_pkg::OP_CODE_FETCH);
  c_rotate: cover property (exec0 && op == bti_pkg::OP_ROTR);
endmodule
`default_nettype wire

// ==== tb/bti_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module bti_mem_model (
  // clock
  input wire logic clk_sys,
  // data memory, i/o space, program memory
  input wire bti_pkg::bti_dm_req_type dm_req,
  output logic [7:0] dm_rdata,
  input wire bti_pkg::bti_io_req_type io_req,
  input wire bti_pkg::bti_pm_req_type pm_req,
  output logic [7:0] pm_rdata
);
  logic [7:0] mem [256];
  logic [7:0] io [64];
  logic [7:0] last = 8'h00;
  logic pm_v = 1'b0;
  logic [15:0] pa = 16'h0000;
  // idle read lines show the inverse so stale data never passes
  assign dm_rdata = dm_req.re ? mem[dm_req.addr[7:0]] : ~last;
  assign pm_rdata = pm_v ? (pa[7:0] ^ 8'h5a) : ~last;
  // writes land on the clock; i/o honours the bit mask
  always @(posedge clk_sys) begin
    if (dm_req.we) mem[dm_req.addr[7:0]] <= dm_req.wdata;
    if (dm_req.re) last <= dm_rdata;
    if (io_req.we) io[io_req.addr] <= (io[io_req.addr] & ~io_req.wmask) |
      (io_req.wdata & io_req.wmask);
    pm_v <= pm_req.re;
    pa <= pm_req.addr;
  end
endmodule
`default_nettype wire

// ==== tb/test_bti_exec_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_bti_exec_unit;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] v;
  logic ack, wdt, brk, busy;
  logic [7:0] dm_rdata, pm_rdata;
  bti_pkg::bti_dm_req_type dm_req;
  bti_pkg::bti_io_req_type io_req;
  bti_pkg::bti_pm_req_type pm_req;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int n, wd = 0, bk = 0;
  logic [7:0] sres [5] = '{8'h02, 8'h40, 8'h03, 8'hc0, 8'hc0};
  logic [7:0] sflg [5] = '{8'h09, 8'h09, 8'h09, 8'h05, 8'h05};
  always #4 clk_sys = ~clk_sys;
  bti_exec_unit DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .dm_req(dm_req),
    .dm_rdata(dm_rdata), .io_req(io_req), .pm_req(pm_req),
    .pm_rdata(pm_rdata), .wdt_restart(wdt), .dbg_break_req(brk),
    .busy(busy));
  bti_mem_model mdl (.clk_sys(clk_sys), .dm_req(dm_req),
    .dm_rdata(dm_rdata), .io_req(io_req), .pm_req(pm_req),
    .pm_rdata(pm_rdata));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // pulse counters and a hang limit well above the run length
  always @(posedge clk_sys) begin
    cycles++;
    if (wdt === 1'b1) wd++;
    if (brk === 1'b1) bk++;
    if (cycles == 4000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; waits for ack however long it takes
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    v = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wbx(1'b0, a, 32'h0);
    chk(v, e);
  endtask
  task automatic sr(input logic [4:0] r, input logic [7:0] d);
    wbx(1'b1, 8'h80 + {1'b0, r, 2'b00}, {24'h0, d});
  endtask
  function automatic logic [7:0] ga(input logic [4:0] r);
    return 8'h80 + {1'b0, r, 2'b00};
  endfunction
  // launch a command and count the cycles that busy stays high
  task automatic run(input logic [4:0] o, input logic [4:0] r,
      input logic [2:0] b, input logic [3:0] pm, input logic [5:0] d,
      input int len);
    // pm packs the mode in its upper half and the pointer in its lower half
    wbx(1'b1, 8'h00, {9'h0, d, pm[3:2], pm[1:0], b, r, o});
    n = 0;
    while (busy === 1'b1) begin
      n++;
      @(posedge clk_sys);
    end
    chk(n, len);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h00ff);
    rd(8'h14, 32'h0);
    for (int i = 0; i < 5; i++) begin
      sr(5'd16, 8'h81);
      wbx(1'b1, 8'h08, 32'h01);
      run(5'd3 + i[4:0], 5'd16, 3'd0, 4'h0, 6'd0, 1);
      rd(ga(5'd16), {24'h0, sres[i]});
      rd(8'h08, {24'h0, sflg[i]});
    end
    wbx(1'b1, 8'h08, 32'h0);
    for (int i = 0; i < 8; i++) begin
      run(5'h0a, 5'd0, i[2:0], 4'h0, 6'd0, 1);
      rd(8'h08, 32'h1 << i);
      run(5'h0b, 5'd0, i[2:0], 4'h0, 6'd0, 1);
      rd(8'h08, 32'h0);
    end
    run(5'h0c, 5'd0, 3'd0, 4'h0, 6'd0, 1);
    rd(8'h08, 32'h80);
    run(5'h0d, 5'd0, 3'd0, 4'h0, 6'd0, 1);
    rd(8'h08, 32'h0);
    run(5'h08, 5'd16, 3'd7, 4'h0, 6'd0, 1);
    rd(8'h08, 32'h40);
    sr(5'd17, 8'h00);
    run(5'h09, 5'd17, 3'd3, 4'h0, 6'd0, 1);
    rd(ga(5'd17), 32'h08);
    rd(8'h08, 32'h40);
    // pointer modes: x at 0x10, y at 0x20, z at 0x30
    sr(5'd26, 8'h10); sr(5'd27, 8'h0); sr(5'd28, 8'h20); sr(5'd29, 8'h0);
    sr(5'd30, 8'h30); sr(5'd31, 8'h0);
    mdl.mem[8'h0f] = 8'ha5;
    mdl.mem[8'h33] = 8'h3c;
    run(5'h0e, 5'd5, 3'd0, 4'h8, 6'd0, 2);
    rd(ga(5'd5), 32'ha5);
    rd(ga(5'd26), 32'h0f);
    run(5'h11, 5'd5, 3'd0, 4'h5, 6'd0, 2);
    chk(mdl.mem[8'h20], 32'ha5);
    rd(ga(5'd28), 32'h21);
    run(5'h0f, 5'd6, 3'd0, 4'h2, 6'd3, 2);
    rd(ga(5'd6), 32'h3c);
    rd(ga(5'd30), 32'h30);
    run(5'h12, 5'd6, 3'd0, 4'h1, 6'd2, 2);
    chk(mdl.mem[8'h23], 32'h3c);
    rd(ga(5'd28), 32'h21);
    run(5'h11, 5'd5, 3'd0, 4'ha, 6'd0, 2);
    chk(mdl.mem[8'h2f], 32'ha5);
    run(5'h0e, 5'd7, 3'd0, 4'h4, 6'd0, 2);
    rd(ga(5'd7), 32'ha5);
    rd(ga(5'd26), 32'h10);
    wbx(1'b1, 8'h04, 32'h40);
    run(5'h13, 5'd6, 3'd0, 4'h0, 6'd0, 2);
    chk(mdl.mem[8'h40], 32'h3c);
    run(5'h10, 5'd8, 3'd0, 4'h0, 6'd0, 2);
    rd(ga(5'd8), 32'h3c);
    run(5'h15, 5'd5, 3'd0, 4'h0, 6'd0, 2);
    chk(mdl.mem[8'hff], 32'ha5);
    rd(8'h0c, 32'h00fe);
    run(5'h16, 5'd9, 3'd0, 4'h0, 6'd0, 2);
    rd(ga(5'd9), 32'ha5);
    rd(8'h0c, 32'h00ff);
    run(5'h14, 5'd0, 3'd0, 4'hc, 6'd0, 3);
    rd(ga(5'd0), 32'h75);
    run(5'h14, 5'd10, 3'd0, 4'h6, 6'd0, 3);
    rd(ga(5'd10), 32'h75);
    rd(ga(5'd30), 32'h30);
    // i/o bits: set two, clear one, flags must stay put
    mdl.io[5] = 8'h00;
    wbx(1'b1, 8'h04, 32'h05);
    run(5'h01, 5'd0, 3'd2, 4'h0, 6'd0, 2);
    run(5'h01, 5'd0, 3'd0, 4'h0, 6'd0, 2);
    run(5'h02, 5'd0, 3'd2, 4'h0, 6'd0, 2);
    chk(mdl.io[5], 32'h01);
    rd(8'h08, 32'h40);
    // let the pulse counters settle past the edge at which busy fell
    run(5'h17, 5'd0, 3'd0, 4'h0, 6'd0, 1);
    @(posedge clk_sys);
    chk(wd, 1);
    run(5'h18, 5'd0, 3'd0, 4'h0, 6'd0, 1);
    @(posedge clk_sys);
    chk(bk, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
